// ### src/ftp_timing_ctrl.sv
// Flash timing control register with write/erase sequencer and read
// timing. Assumes the core's special-function bus and the flash array
// run on clk; all inputs are synchronous to it.
`timescale 1ns/1ps
`default_nettype none
`include "ftp_map.svh"
module ftp_timing_ctrl
	import ftp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output var  logic [7:0] sfr_rdata,
	input  wire logic       program_store_write_allow,
	input  wire logic       program_store_erase_allow,
	input  wire logic       flash_op_req,
	input  wire logic       flash_op_erase,
	output var  logic       flash_op_ack,
	output var  logic       flash_op_busy,
	output var  logic       flash_op_done,
	output var  logic       flash_hv_on,
	input  wire logic       flash_read_req,
	output var  logic       flash_read_en,
	output var  logic       one_shot_timer_on,
	output var  logic       read_always_on,
	output var  logic [3:0] write_erase_clock_divider,
	output var  logic       write_erase_blocked
);
	localparam logic [7:0] ONESHOT_CYC = 8'(`FTP_ONESHOT_CYC);

	ftp_tick_if    tif ();
	ftp_byte_t     ctl_r;
	ftp_op_state_t st_r;
	ftp_op_state_t st_nxt;
	logic [7:0]    ticks_r;
	logic [7:0]    os_cnt_r;
	logic          hit;
	logic          allow;
	logic          blocked;

	// ==================================================================
	// Register
	assign hit = (sfr_addr == `FTP_REG_ADDR);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctl_r <= `FTP_REG_RESET;
		end else if (sfr_wr && hit) begin
			ctl_r <= sfr_wdata & ~`FTP_RSVD_MASK;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd && hit) begin
			sfr_rdata <= ctl_r & ~`FTP_RSVD_MASK;
		end else begin
			sfr_rdata <= 8'h00;
		end
	end

	assign one_shot_timer_on         = ctl_r[`FTP_BIT_ONE_SHOT];
	assign read_always_on            = ctl_r[`FTP_BIT_READ_ALWAYS];
	assign write_erase_clock_divider = ctl_r[`FTP_DIV_MSB:`FTP_DIV_LSB];
	assign blocked                   = (write_erase_clock_divider == `FTP_CODE_OFF);
	assign write_erase_blocked       = blocked;

	// ==================================================================
	// Prescaler
	assign tif.code = write_erase_clock_divider;

	ftp_prescale u_pre (
		.clk  (clk),
		.rstn (rstn),
		.tif  (tif)
	);

	// ==================================================================
	// Write/erase sequencer
	assign allow = !blocked && (flash_op_erase ? program_store_erase_allow
		: program_store_write_allow);
	assign flash_op_ack  = (st_r == FTP_IDLE) && flash_op_req && allow;
	assign flash_op_busy = (st_r == FTP_BUSY);

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			FTP_IDLE: begin
				if (flash_op_ack) begin
					st_nxt = FTP_BUSY;
				end
			end
			FTP_BUSY: begin
				if (blocked) begin
					st_nxt = FTP_IDLE;
				end else if (tif.tick && ticks_r == 8'h01) begin
					st_nxt = FTP_DONE;
				end
			end
			FTP_DONE: begin
				st_nxt = FTP_IDLE;
			end
			default: begin
				st_nxt = FTP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= FTP_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// High-voltage pulse length is a count of prescaled ticks
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ticks_r <= 8'h00;
		end else if (flash_op_ack) begin
			ticks_r <= flash_op_erase ? `FTP_ERASE_TICKS : `FTP_WRITE_TICKS;
		end else if (st_r == FTP_BUSY && tif.tick && ticks_r != 8'h00) begin
			ticks_r <= ticks_r - 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flash_hv_on   <= 1'b0;
			flash_op_done <= 1'b0;
		end else begin
			flash_hv_on   <= (st_nxt == FTP_BUSY);
			flash_op_done <= (st_nxt == FTP_DONE);
		end
	end

	// ==================================================================
	// Read timing
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			os_cnt_r <= 8'h00;
		end else if (flash_read_req && one_shot_timer_on) begin
			os_cnt_r <= ONESHOT_CYC;
		end else if (os_cnt_r != 8'h00) begin
			os_cnt_r <= os_cnt_r - 8'h01;
		end
	end

	// Without the one-shot the array is enabled for the whole request
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flash_read_en <= 1'b0;
		end else if (read_always_on) begin
			flash_read_en <= 1'b1;
		end else if (one_shot_timer_on) begin
			flash_read_en <= flash_read_req || (os_cnt_r > 8'h01);
		end else begin
			flash_read_en <= flash_read_req;
		end
	end

	// ==================================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_wr_reg;
		sfr_wr && hit;
	endsequence
	sequence s_rd_reg;
		sfr_rd && hit && !sfr_wr;
	endsequence

	chk_reg_reads_zero: assert property (s_rd_reg |=> sfr_rdata[5:4] == 2'b00)
		else $error("reserved bits read nonzero");
	chk_reg_write_back: assert property (s_wr_reg ##1 s_rd_reg
		|=> sfr_rdata == ($past(sfr_wdata, 2) & 8'hCF))
		else $error("readback differs from write");
	chk_one_shot_bit: assert property (s_wr_reg |=> one_shot_timer_on == $past(sfr_wdata[7]))
		else $error("one-shot enable not taken from bit 7");
	chk_read_always: assert property (read_always_on |=> flash_read_en)
		else $error("read enable dropped in read-always mode");
	chk_block_ack: assert property (blocked |-> !flash_op_ack ##1 !flash_hv_on)
		else $error("write or erase started while blocked");
	chk_write_pulse: assert property ((flash_op_ack && !flash_op_erase
		&& (write_erase_clock_divider == 4'h0)) ##1 (write_erase_clock_divider == 4'h0) [*2]
		|=> flash_op_done)
		else $error("write pulse length wrong at code zero");
	chk_reset_value: assert property ($rose(rstn) |-> ctl_r == 8'h8F)
		else $error("reset value wrong");
endmodule
`default_nettype wire

// ### common/ftp_map.svh
// Register address, field positions, reset values and timing counts
// for the flash timing prescaler control block.
// Included by bare name; definitions only.
`ifndef FTP_MAP_SVH
`define FTP_MAP_SVH

// ==================================================================
// Register map
`define FTP_REG_ADDR        8'hB6
`define FTP_REG_RESET       8'h8F
`define FTP_BIT_ONE_SHOT    7
`define FTP_BIT_READ_ALWAYS 6
`define FTP_DIV_MSB         3
`define FTP_DIV_LSB         0
`define FTP_RSVD_MASK       8'h30

// ==================================================================
// Prescaler codes
`define FTP_CODE_OFF        4'hF
`define FTP_CODE_MAX        4'hA
`define FTP_CNT_W           11

// ==================================================================
// Timing
`define FTP_CLK_KHZ         20000
`define FTP_ONESHOT_NS      100
`define FTP_ONESHOT_CYC     ((`FTP_ONESHOT_NS * `FTP_CLK_KHZ + 999999) / 1000000)
`define FTP_WRITE_TICKS     8'h02
`define FTP_ERASE_TICKS     8'h0A

`endif

// ### common/ftp_pkg.sv
// Types shared by the flash timing prescaler control block.
// Assumes ftp_map.svh is on the include path.
`default_nettype none
package ftp_pkg;
	typedef logic [3:0] ftp_code_t;
	typedef logic [7:0] ftp_byte_t;
	typedef enum logic [1:0] {
		FTP_IDLE = 2'b00,
		FTP_BUSY = 2'b01,
		FTP_DONE = 2'b10
	} ftp_op_state_t;
endpackage
`default_nettype wire

// ### common/ftp_tick_if.sv
// Link between the control register logic and its prescaler.
// Assumes both ends share clk and rstn.
`timescale 1ns/1ps
`default_nettype none
interface ftp_tick_if;
	import ftp_pkg::*;
	ftp_code_t code;
	logic      tick;
	modport ctrl (output code, input tick);
	modport pre  (input code, output tick);
endinterface
`default_nettype wire

// ### src/ftp_prescale.sv
// Write/erase timebase: one tick every 2**code system clocks for codes 0 to 10; codes 11 to 14 give one every 2048.
// Assumes code is steady except for register writes; all ones stops it.
`timescale 1ns/1ps
`default_nettype none
`include "ftp_map.svh"
module ftp_prescale
	import ftp_pkg::*;
(
	input  wire logic clk,
	input  wire logic rstn,
	ftp_tick_if.pre   tif
);
	logic [`FTP_CNT_W-1:0] cnt_r;
	logic [`FTP_CNT_W-1:0] limit;
	logic                  run;

	// ==================================================================
	// Divider
	assign run   = (tif.code != `FTP_CODE_OFF);
	assign limit = (tif.code > `FTP_CODE_MAX) ? {`FTP_CNT_W{1'b1}}
		: (`FTP_CNT_W'(1) << tif.code) - `FTP_CNT_W'(1);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= '0;
		end else if (!run || cnt_r >= limit) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + `FTP_CNT_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tif.tick <= 1'b0;
		end else begin
			tif.tick <= run && (cnt_r >= limit);
		end
	end

	// ==================================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	chk_no_tick_off: assert property (!run |=> !tif.tick)
		else $error("tick while prescaler is off");
	chk_tick_div1: assert property ((tif.code == 4'h0) [*3] |-> tif.tick)
		else $error("code zero must tick every clock");
endmodule
`default_nettype wire

// ### tb/ftp_flash_model.sv
// Flash array side: raises write/erase requests and measures the pulse.
// Assumes go comes from the bench and is changed at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module ftp_flash_model (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        go,
	input  wire logic        flash_op_ack,
	input  wire logic        flash_hv_on,
	input  wire logic        flash_op_done,
	output logic             flash_op_req,
	output var logic [11:0]  hv_cycles,
	output var logic [3:0]   done_cnt
);
	logic taken_r;
	// Request held until the edge that acknowledges it
	assign flash_op_req = go & ~taken_r;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			taken_r   <= 1'b0;
			hv_cycles <= 12'h000;
			done_cnt  <= 4'h0;
		end else begin
			taken_r   <= go & (taken_r | flash_op_ack);
			hv_cycles <= go ? hv_cycles + {11'h000, flash_hv_on} : 12'h000;
			done_cnt  <= done_cnt + {3'h0, flash_op_done};
		end
	end
endmodule
`default_nettype wire

// ### tb/test_ftp_timing_ctrl.sv
// Self-checking bench for the flash timing control register.
// Assumes the design and the flash model run on one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_ftp_timing_ctrl;
	import ftp_pkg::*;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  sfr_addr = 8'h00;
	logic        sfr_wr = 1'b0;
	logic        sfr_rd = 1'b0;
	logic [7:0]  sfr_wdata = 8'h00;
	logic [7:0]  sfr_rdata;
	logic        wa = 1'b1;
	logic        ea = 1'b1;
	logic        go = 1'b0;
	logic        erase = 1'b0;
	logic        rreq = 1'b0;
	logic        req, ack, busy, done, hv, ren, osh, rall, blk;
	logic [3:0]  div;
	logic [3:0]  done_cnt;
	logic [11:0] hv_cycles;
	int          errors = 0;
	int          checked = 0;

	always #25 clk = ~clk;

	ftp_timing_ctrl u_ftp_timing_ctrl (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.program_store_write_allow(wa), .program_store_erase_allow(ea),
		.flash_op_req(req), .flash_op_erase(erase), .flash_op_ack(ack),
		.flash_op_busy(busy), .flash_op_done(done), .flash_hv_on(hv),
		.flash_read_req(rreq), .flash_read_en(ren), .one_shot_timer_on(osh),
		.read_always_on(rall), .write_erase_clock_divider(div), .write_erase_blocked(blk));

	ftp_flash_model u_ftp_flash_model (.clk(clk), .rstn(rstn), .go(go),
		.flash_op_ack(ack), .flash_hv_on(hv), .flash_op_done(done),
		.flash_op_req(req), .hv_cycles(hv_cycles), .done_cnt(done_cnt));

	// =====================================================
	// Checks and bus tasks, all entered at a falling edge
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		chk("rdata", {4'h0, exp}, {4'h0, sfr_rdata});
		@(negedge clk);
		chk("rdata_idle", 12'h000, {4'h0, sfr_rdata});
	endtask

	task automatic fields(input logic [7:0] exp);
		chk("fields", {4'h0, exp}, {4'h0, osh, rall, 2'b00, div});
	endtask

	task automatic op(input logic er, input int lo, input int hi, input logic [3:0] dn);
		erase = er;
		go = 1'b1;
		for (int i = 0; i < hi + 20 && done !== 1'b1; i++) @(negedge clk);
		chk("hv_len_ok", 12'h001, {11'h000, (hv_cycles >= lo && hv_cycles <= hi)});
		go = 1'b0;
		@(negedge clk);
		chk("done_cnt", {8'h00, dn}, {8'h00, done_cnt});
	endtask

	task automatic give_verdict;
		if (errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// =====================================================
	// Tests
	initial begin
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		fields(8'h8F);
		chk("blocked", 12'h001, {11'h000, blk});
		rd(8'hB6, 8'h8F);
		wr(8'hB6, 8'hFF);
		rd(8'hB6, 8'hCF);
		op(1'b0, 0, 0, 4'h0);
		wr(8'hB6, 8'h41);
		fields(8'h41);
		chk("blocked_off", 12'h000, {11'h000, blk});
		chk("read_always_en", 12'h001, {11'h000, ren});
		wr(8'hB7, 8'h00);
		rd(8'hB6, 8'h41);
		rd(8'hB7, 8'h00);
		wr(8'hB6, 8'h80);
		rreq = 1'b1;
		@(negedge clk);
		rreq = 1'b0;
		chk("one_shot_c1", 12'h001, {11'h000, ren});
		@(negedge clk);
		chk("one_shot_c2", 12'h001, {11'h000, ren});
		@(negedge clk);
		chk("one_shot_c3", 12'h000, {11'h000, ren});
		wr(8'hB6, 8'h00);
		rreq = 1'b1;
		@(negedge clk);
		rreq = 1'b0;
		chk("no_one_shot_c1", 12'h001, {11'h000, ren});
		@(negedge clk);
		chk("no_one_shot_c2", 12'h000, {11'h000, ren});
		op(1'b0, 2, 2, 4'h1);
		op(1'b1, 10, 10, 4'h2);
		wa = 1'b0;
		op(1'b0, 0, 0, 4'h2);
		wa = 1'b1;
		wr(8'hB6, 8'h89);
		op(1'b0, 513, 1024, 4'h3);
		wr(8'hB6, 8'h82);
		erase = 1'b1;
		go = 1'b1;
		repeat (6) @(negedge clk);
		chk("abort_started", 12'h001, {11'h000, hv});
		wr(8'hB6, 8'h8F);
		repeat (3) @(negedge clk);
		chk("abort_hv", 12'h000, {10'h000, busy, hv});
		go = 1'b0;
		@(negedge clk);
		chk("abort_done", 12'h003, {8'h00, done_cnt});
		give_verdict;
	end

	initial begin
		repeat (4000) @(posedge clk);
		errors++;
		give_verdict;
	end
endmodule
`default_nettype wire
